// file: hdl/message_queue_unit.sv
// Purpose: messaging unit keeping four circular frame-address queues in local memory
// Assumes: pci_req and lcl_req are one-cycle requests synchronous to clk
// Notes: pci answers are one-cycle pulses; a busy engine answers pci with retry
// Overview of operation
// - inbound port read frees, write posts
// - outbound port read posted, write frees
// - region base from base bits 31:20
// - every queue access one 32-bit word
// - sizes 4K to 64K entries, shared
// - queues at base plus 0..3 sizes
// - access address is base plus index times size plus pointer
// - empty when disabled or pointers equal
// - empty clears when enabled and unequal, or on head catch-up
// - empty sets again on tail catch-up
// - full clears when disabled or unequal
// - full sets when head reaches tail
// - write at head, read at tail
// - hardware pointers wrap at queue size
// - empty inbound free read returns ones
// - inbound read fetches tail, bumps tail
// - prefetch next inbound free entry when enabled
// - outbound free overflow drives error interrupt
// - inbound post write, retry until done
// - interrupt while inbound post not empty
// - empty outbound post read returns ones
`timescale 1ns/1ns
`include "mqu_map.svh"
module message_queue_unit (
  input wire logic clk,
  input wire logic srst,
  input wire logic pci_req,
  input wire logic pci_we,
  input wire logic [7:0] pci_addr,
  input wire logic [31:0] pci_wdata,
  output logic pci_ack,
  output logic pci_retry,
  output logic [31:0] pci_rdata,
  input wire logic lcl_req,
  input wire logic lcl_we,
  input wire logic [7:0] lcl_addr,
  input wire logic [31:0] lcl_wdata,
  output logic lcl_ack,
  output logic [31:0] lcl_rdata,
  output logic lm_req,
  output logic lm_we,
  output logic [31:0] lm_addr,
  output logic [31:0] lm_wdata,
  input wire logic lm_ack,
  input wire logic [31:0] lm_rdata,
  output logic local_interrupt,
  output logic local_error_interrupt_n
);
  mem_cmd_if mcmd ();
  // registers
  logic [5:0] cfg_q; // queue config register: enable and size
  logic [11:0] base_q; // queue base register bits 31:20
  logic pf_en_q; // inbound free prefetch enable
  logic ip_mask_q; // inbound post interrupt mask
  logic ovf_q, ovf_d; // outbound free overflow, sticky
  mqu_pkg::ptr_t head_q [4], tail_q [4]; // pointers per queue
  mqu_pkg::ptr_t head_d [4], tail_d [4]; // pointer values after this edge
  logic [3:0] head_inc, tail_inc; // hardware increments this cycle
  logic [3:0] empty, full; // flags per queue
  // engine state
  mqu_pkg::engine_state_e state_q;
  logic [1:0] qsel_q; // queue served by the open memory access
  logic pf_valid_q; // prefetch register holds the tail entry
  logic [31:0] pf_data_q; // prefetch register
  // decoded controls
  logic en, idle, serve_pf, start_pf;
  logic take_in_wr, take_out_wr, take_in_rd, take_out_rd; // queue port requests taken
  mqu_pkg::ptr_t qsize; // bytes per queue
  assign en = cfg_q[`MQU_CFG_ENABLE_BIT];
  assign qsize = mqu_pkg::queue_bytes(cfg_q[`MQU_CFG_SIZE_MSB:`MQU_CFG_SIZE_LSB]);
  assign idle = (state_q == mqu_pkg::ST_IDLE);
  assign take_in_wr = idle && pci_req && pci_we && pci_addr == `MQU_OFF_INBOUND_PORT;
  assign take_in_rd = idle && pci_req && !pci_we && pci_addr == `MQU_OFF_INBOUND_PORT;
  assign take_out_wr = idle && pci_req && pci_we && pci_addr == `MQU_OFF_OUTBOUND_PORT;
  assign take_out_rd = idle && pci_req && !pci_we && pci_addr == `MQU_OFF_OUTBOUND_PORT;
  assign serve_pf = take_in_rd && !empty[`MQU_Q_INBOUND_FREE] && pf_valid_q;
  assign start_pf = idle && !pci_req && en && pf_en_q && !pf_valid_q
                    && !empty[`MQU_Q_INBOUND_FREE];
  // memory command for the access begun this cycle
  always_comb begin
    mcmd.start = 1'b0;
    mcmd.we = 1'b0;
    mcmd.wdata = pci_wdata;
    mcmd.addr = 32'h0000_0000;
    if (take_in_wr) begin
      mcmd.start = 1'b1;
      mcmd.we = 1'b1;
      mcmd.addr = mqu_pkg::queue_addr(base_q, `MQU_Q_INBOUND_POST, qsize,
                                      head_q[`MQU_Q_INBOUND_POST]);
    end else if (take_out_wr) begin
      mcmd.start = 1'b1;
      mcmd.we = 1'b1;
      mcmd.addr = mqu_pkg::queue_addr(base_q, `MQU_Q_OUTBOUND_FREE, qsize,
                                      head_q[`MQU_Q_OUTBOUND_FREE]);
    end else if ((take_in_rd && !empty[`MQU_Q_INBOUND_FREE] && !pf_valid_q) || start_pf) begin
      mcmd.start = 1'b1;
      mcmd.addr = mqu_pkg::queue_addr(base_q, `MQU_Q_INBOUND_FREE, qsize,
                                      tail_q[`MQU_Q_INBOUND_FREE]);
    end else if (take_out_rd && !empty[`MQU_Q_OUTBOUND_POST]) begin
      mcmd.start = 1'b1;
      mcmd.addr = mqu_pkg::queue_addr(base_q, `MQU_Q_OUTBOUND_POST, qsize,
                                      tail_q[`MQU_Q_OUTBOUND_POST]);
    end
  end
  // pointer increments owed by hardware
  always_comb begin
    head_inc = 4'h0;
    tail_inc = 4'h0;
    // head after write, tail after read
    head_inc[qsel_q] = (state_q == mqu_pkg::ST_WRITE) && mcmd.done;
    tail_inc[qsel_q] = (state_q == mqu_pkg::ST_READ) && mcmd.done;
    if (serve_pf) begin
      tail_inc[`MQU_Q_INBOUND_FREE] = 1'b1;
    end
  end
  // next pointer values: hardware step wins over a software write
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      head_d[i] = head_q[i];
      tail_d[i] = tail_q[i];
      if (head_inc[i]) begin
        head_d[i] = mqu_pkg::next_ptr(head_q[i], qsize);
      end else if (lcl_req && lcl_we && lcl_addr ==
                   8'(`MQU_OFF_PTR_FIRST + `MQU_PTR_STRIDE * i)) begin
        head_d[i] = lcl_wdata[19:0];
      end
      if (tail_inc[i]) begin
        tail_d[i] = mqu_pkg::next_ptr(tail_q[i], qsize);
      end else if (lcl_req && lcl_we && lcl_addr ==
                   8'(`MQU_OFF_PTR_FIRST + `MQU_PTR_STRIDE * i + `MQU_PTR_TAIL_STEP)) begin
        tail_d[i] = lcl_wdata[19:0];
      end
    end
  end
  // pointer registers
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (srst) begin
        head_q[i] <= 20'h0_0000;
        tail_q[i] <= 20'h0_0000;
      end else begin
        head_q[i] <= head_d[i];
        tail_q[i] <= tail_d[i];
      end
    end
  end
  // empty and full flags per queue; a software pointer write is a step too
  for (genvar g = 0; g < 4; g++) begin : g_flags
    queue_flags u_flags (.clk(clk), .srst(srst), .en(en), .head_d(head_d[g]),
      .tail_d(tail_d[g]), .head_inc(head_d[g] != head_q[g]),
      .tail_inc(tail_d[g] != tail_q[g]), .empty(empty[g]), .full(full[g]));
  end
  // engine sequencing
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= mqu_pkg::ST_IDLE;
      qsel_q <= 2'd0;
    end else begin
      case (state_q)
        mqu_pkg::ST_IDLE: begin
          if (take_in_wr) begin
            state_q <= mqu_pkg::ST_WRITE;
            qsel_q <= `MQU_Q_INBOUND_POST;
          end else if (take_out_wr) begin
            state_q <= mqu_pkg::ST_WRITE;
            qsel_q <= `MQU_Q_OUTBOUND_FREE;
          end else if (take_in_rd && !empty[`MQU_Q_INBOUND_FREE] && !pf_valid_q) begin
            state_q <= mqu_pkg::ST_READ;
            qsel_q <= `MQU_Q_INBOUND_FREE;
          end else if (take_out_rd && !empty[`MQU_Q_OUTBOUND_POST]) begin
            state_q <= mqu_pkg::ST_READ;
            qsel_q <= `MQU_Q_OUTBOUND_POST;
          end else if (start_pf) begin
            state_q <= mqu_pkg::ST_PREFETCH;
            qsel_q <= `MQU_Q_INBOUND_FREE;
          end
        end
        mqu_pkg::ST_WRITE, mqu_pkg::ST_READ, mqu_pkg::ST_PREFETCH: begin
          // one word per access, then back to idle
          if (mcmd.done) begin
            state_q <= mqu_pkg::ST_IDLE;
          end
        end
        default: state_q <= mqu_pkg::ST_IDLE;
      endcase
    end
  end
  // prefetch register
  always_ff @(posedge clk) begin
    if (srst) begin
      pf_valid_q <= 1'b0;
      pf_data_q <= 32'h0000_0000;
    end else if (!en || !pf_en_q || serve_pf) begin
      // stale or consumed word is dropped
      pf_valid_q <= 1'b0;
    end else if (state_q == mqu_pkg::ST_PREFETCH && mcmd.done) begin
      pf_valid_q <= 1'b1;
      pf_data_q <= mcmd.rdata;
    end
  end
  // pci target answers
  always_ff @(posedge clk) begin
    if (srst) begin
      pci_ack <= 1'b0;
      pci_retry <= 1'b0;
      pci_rdata <= 32'h0000_0000;
    end else begin
      pci_ack <= 1'b0;
      pci_retry <= pci_req && !idle;
      if (state_q == mqu_pkg::ST_READ && mcmd.done) begin
        pci_ack <= 1'b1;
        pci_rdata <= mcmd.rdata;
      end else if (serve_pf) begin
        pci_ack <= 1'b1;
        pci_rdata <= pf_data_q;
      end else if (take_in_rd && empty[`MQU_Q_INBOUND_FREE]) begin
        pci_ack <= 1'b1;
        pci_rdata <= `MQU_EMPTY_WORD;
      end else if (take_out_rd && empty[`MQU_Q_OUTBOUND_POST]) begin
        pci_ack <= 1'b1;
        pci_rdata <= `MQU_EMPTY_WORD;
      end else if (idle && pci_req && (pci_we || (!take_in_rd && !take_out_rd))) begin
        // posted writes and unmapped offsets complete at once
        pci_ack <= 1'b1;
        pci_rdata <= 32'h0000_0000;
      end
    end
  end
  // overflow when outbound free head catches tail
  always_comb begin
    ovf_d = ovf_q;
    if (lcl_req && lcl_we && lcl_addr == `MQU_OFF_STATUS && lcl_wdata[`MQU_QSR_OVERFLOW_BIT]) begin
      ovf_d = 1'b0;
    end
    // set wins over a same-cycle clear
    if (en && head_inc[`MQU_Q_OUTBOUND_FREE]
        && head_d[`MQU_Q_OUTBOUND_FREE] == tail_d[`MQU_Q_OUTBOUND_FREE]) begin
      ovf_d = 1'b1;
    end
  end
  // local control registers
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q <= `MQU_CFG_RESET;
      base_q <= 12'h000;
      pf_en_q <= 1'b0;
      ip_mask_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
      if (lcl_req && lcl_we) begin
        case (lcl_addr)
          `MQU_OFF_CONFIG: cfg_q <= lcl_wdata[5:0];
          `MQU_OFF_BASE: base_q <= lcl_wdata[31:`MQU_BASE_LSB];
          `MQU_OFF_STATUS: begin
            pf_en_q <= lcl_wdata[`MQU_QSR_PREFETCH_BIT];
            ip_mask_q <= lcl_wdata[`MQU_QSR_IP_MASK_BIT];
          end
          default: ; // pointers are handled apart
        endcase
      end
    end
  end
  // local register reads, answered the next cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      lcl_ack <= 1'b0;
      lcl_rdata <= 32'h0000_0000;
    end else begin
      lcl_ack <= lcl_req;
      lcl_rdata <= 32'h0000_0000;
      if (lcl_req && !lcl_we) begin
        case (lcl_addr)
          `MQU_OFF_CONFIG: lcl_rdata <= {26'h000_0000, cfg_q};
          `MQU_OFF_BASE: lcl_rdata <= {base_q, 20'h0_0000};
          `MQU_OFF_STATUS: lcl_rdata <= {25'h000_0000, ovf_q, !empty[`MQU_Q_INBOUND_POST],
                                         ip_mask_q, pf_en_q, 3'h0};
          default: begin
            for (int i = 0; i < 4; i++) begin
              if (lcl_addr == 8'(`MQU_OFF_PTR_FIRST + `MQU_PTR_STRIDE * i)) begin
                lcl_rdata <= {12'h000, head_q[i]};
              end
              if (lcl_addr == 8'(`MQU_OFF_PTR_FIRST + `MQU_PTR_STRIDE * i
                                 + `MQU_PTR_TAIL_STEP)) begin
                lcl_rdata <= {12'h000, tail_q[i]};
              end
            end
          end
        endcase
      end
    end
  end
  // interrupt outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      local_interrupt <= 1'b0;
      local_error_interrupt_n <= 1'b1;
    end else begin
      // level while inbound post holds entries
      local_interrupt <= !empty[`MQU_Q_INBOUND_POST] && !ip_mask_q;
      local_error_interrupt_n <= !ovf_q;
    end
  end
  // local memory access engine
  local_mem_master u_master (.clk(clk), .srst(srst), .cmd(mcmd.master), .lm_req(lm_req),
    .lm_we(lm_we), .lm_addr(lm_addr), .lm_wdata(lm_wdata), .lm_ack(lm_ack),
    .lm_rdata(lm_rdata));
endmodule

// file: hdl/mqu_map.svh
// Purpose: offsets, field positions, reset values and fixed words of the message queue unit
// Assumes: byte offsets on the pci target port and on the local register port
// Notes: definitions only
`ifndef MQU_MAP_SVH
`define MQU_MAP_SVH

// pci target queue ports
`define MQU_OFF_INBOUND_PORT 8'h40
`define MQU_OFF_OUTBOUND_PORT 8'h44

// local register port offsets
`define MQU_OFF_CONFIG 8'h00
`define MQU_OFF_BASE 8'h04
`define MQU_OFF_STATUS 8'h08
`define MQU_OFF_PTR_FIRST 8'h10
`define MQU_PTR_STRIDE 8'h08
`define MQU_PTR_TAIL_STEP 8'h04

// queue config register fields
`define MQU_CFG_ENABLE_BIT 0
`define MQU_CFG_SIZE_LSB 1
`define MQU_CFG_SIZE_MSB 5
`define MQU_CFG_RESET 6'h00

// queue status/control register fields
`define MQU_QSR_PREFETCH_BIT 3
`define MQU_QSR_IP_MASK_BIT 4
`define MQU_QSR_IP_STATUS_BIT 5
`define MQU_QSR_OVERFLOW_BIT 6

// base address field of the queue base register
`define MQU_BASE_LSB 20

// queue indices inside the region
`define MQU_Q_INBOUND_FREE 2'd0
`define MQU_Q_INBOUND_POST 2'd1
`define MQU_Q_OUTBOUND_POST 2'd2
`define MQU_Q_OUTBOUND_FREE 2'd3

// fixed words
`define MQU_EMPTY_WORD 32'hFFFF_FFFF
`define MQU_ENTRY_BYTES 20'h0_0004
`define MQU_SIZE_SHIFT 14

`endif

// file: hdl/mqu_pkg.sv
// Purpose: types and helper functions of the message queue unit
// Assumes: mqu_map.svh holds the numbers
// Notes: pointers are byte offsets inside one queue
`include "mqu_map.svh"
package mqu_pkg;
  // byte offset inside one queue
  typedef logic [19:0] ptr_t;
  // engine states
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ, ST_PREFETCH} engine_state_e;

  // size field one-hot (4K..64K entries) to bytes per queue
  function automatic ptr_t queue_bytes(input logic [4:0] size_field);
    queue_bytes = ptr_t'({15'h0000, size_field} << `MQU_SIZE_SHIFT);
  endfunction

  // advance by one entry, wrapping at the queue size
  function automatic ptr_t next_ptr(input ptr_t ptr, input ptr_t size);
    ptr_t sum;
    sum = ptr + `MQU_ENTRY_BYTES;
    next_ptr = (sum >= size) ? 20'h0_0000 : sum;
  endfunction

  // base + index * size + pointer
  function automatic logic [31:0] queue_addr(input logic [11:0] base, input logic [1:0] idx,
                                             input ptr_t size, input ptr_t ptr);
    logic [31:0] span;
    span = {12'h000, size} * {30'h0000_0000, idx};
    queue_addr = {base, 20'h0_0000} + span + {12'h000, ptr};
  endfunction
endpackage

// file: hdl/mem_cmd_if.sv
// Purpose: command and response path from the queue engine to the local memory master
// Assumes: one command outstanding at a time
// Notes: start and done are one-cycle pulses
`timescale 1ns/1ns
interface mem_cmd_if;
  logic start; // begin one 32-bit access
  logic we; // 1 write, 0 read
  logic [31:0] addr; // local byte address
  logic [31:0] wdata; // write word
  logic done; // access finished
  logic [31:0] rdata; // read word, valid with done
  modport engine (output start, we, addr, wdata, input done, rdata);
  modport master (input start, we, addr, wdata, output done, rdata);
endinterface

// file: hdl/local_mem_master.sv
// Purpose: carries one single-word access at a time onto the local memory port
// Assumes: the memory holds lm_ack high for one cycle per access
// Notes: start is ignored while an access is open
`timescale 1ns/1ns
module local_mem_master (
  input wire logic clk,
  input wire logic srst,
  mem_cmd_if.master cmd,
  output logic lm_req,
  output logic lm_we,
  output logic [31:0] lm_addr,
  output logic [31:0] lm_wdata,
  input wire logic lm_ack,
  input wire logic [31:0] lm_rdata
);
  // request is held until the memory acknowledges it
  always_ff @(posedge clk) begin
    if (srst) begin
      lm_req <= 1'b0;
      lm_we <= 1'b0;
      lm_addr <= 32'h0000_0000;
      lm_wdata <= 32'h0000_0000;
    end else if (!lm_req && cmd.start) begin
      lm_req <= 1'b1;
      lm_we <= cmd.we;
      lm_addr <= cmd.addr;
      lm_wdata <= cmd.wdata;
    end else if (lm_req && lm_ack) begin
      lm_req <= 1'b0;
    end
  end

  // response pulse and captured read word
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd.done <= 1'b0;
      cmd.rdata <= 32'h0000_0000;
    end else begin
      cmd.done <= lm_req && lm_ack;
      if (lm_req && lm_ack) begin
        cmd.rdata <= lm_rdata;
      end
    end
  end
endmodule

// file: hdl/queue_flags.sv
// Purpose: empty and full flags of one circular queue
// Assumes: head_d and tail_d are the pointer values taking effect this edge
// Notes: equal pointers mean empty unless a head increment made them equal
`timescale 1ns/1ns
module queue_flags (
  input wire logic clk,
  input wire logic srst,
  input wire logic en,
  input wire mqu_pkg::ptr_t head_d,
  input wire mqu_pkg::ptr_t tail_d,
  input wire logic head_inc,
  input wire logic tail_inc,
  output logic empty,
  output logic full
);
  // flag update, disable dominates
  always_ff @(posedge clk) begin
    if (srst || !en) begin
      empty <= 1'b1;
      full <= 1'b0;
    end else if (tail_inc && tail_d == head_d) begin
      empty <= 1'b1;
      full <= 1'b0;
    end else if (head_inc && head_d == tail_d) begin
      empty <= 1'b0;
      full <= 1'b1;
    end else if (head_d != tail_d) begin
      empty <= 1'b0;
      full <= 1'b0;
    end
  end
endmodule

// file: tb/mqu_asserts.sv
// Purpose: port assertions of the message queue unit
// Assumes: one clock clk, synchronous reset srst
// Notes: bound to the top module at the foot
`timescale 1ns/1ns
`include "mqu_map.svh"
module mqu_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic pci_req,
  input wire logic pci_we,
  input wire logic [7:0] pci_addr,
  input wire logic [31:0] pci_wdata,
  input wire logic pci_ack,
  input wire logic pci_retry,
  input wire logic lcl_req,
  input wire logic lcl_we,
  input wire logic lcl_ack,
  input wire logic [31:0] lcl_rdata,
  input wire logic lm_req,
  input wire logic lm_we,
  input wire logic [31:0] lm_addr,
  input wire logic [31:0] lm_wdata,
  input wire logic lm_ack,
  input wire logic local_error_interrupt_n
);
  logic [3:0] since_wr_q; // cycles since a memory write ended
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // age of the last finished memory write, saturating
  always_ff @(posedge clk) begin
    if (srst || (lm_ack && lm_we)) begin
      since_wr_q <= 4'h0;
    end else if (since_wr_q != 4'hF) begin
      since_wr_q <= since_wr_q + 4'h1;
    end
  end
  AST_LCL_WR_ACK: assert property (
    lcl_req && lcl_we |=> lcl_ack && lcl_rdata == 32'h0000_0000) else $error("no write answer");
  AST_LM_HOLD: assert property (
    lm_req && !lm_ack |=> lm_req && $stable(lm_addr) && $stable(lm_wdata) && $stable(lm_we))
    else $error("memory access changed while open");
  AST_LM_ALIGN: assert property (lm_req |-> lm_addr[1:0] == 2'b00)
    else $error("memory address not word aligned");
  AST_LM_CLOSE: assert property (lm_req && lm_ack |=> !lm_req)
    else $error("memory access not closed");
  AST_PCI_ANSWER: assert property (pci_req |=> pci_ack || pci_retry || lm_req)
    else $error("pci request not answered");
  AST_ACK_EXCL: assert property (!(pci_ack && pci_retry))
    else $error("ack and retry together");
  AST_IN_POST: assert property (
    pci_req && pci_we && pci_addr == `MQU_OFF_INBOUND_PORT ##1 pci_ack
    |-> lm_req && lm_we && lm_wdata == $past(pci_wdata)) else $error("inbound post not written");
  AST_OUT_FREE: assert property (
    pci_req && pci_we && pci_addr == `MQU_OFF_OUTBOUND_PORT ##1 pci_ack
    |-> lm_req && lm_we && lm_wdata == $past(pci_wdata)) else $error("outbound free not written");
  AST_ERR_CAUSE: assert property ($fell(local_error_interrupt_n) |-> since_wr_q <= 4'h6)
    else $error("error interrupt without a free list write");
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    srst |=> !lm_req && !pci_ack && local_error_interrupt_n) else $error("reset state wrong");
  // main scenarios reached
  cover property (pci_retry);
  cover property ($fell(local_error_interrupt_n));
  cover property (lm_req && lm_ack && !lm_we);
endmodule

bind message_queue_unit mqu_asserts i_mqu_asserts (.clk(clk), .srst(srst), .pci_req(pci_req),
  .pci_we(pci_we), .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_ack(pci_ack),
  .pci_retry(pci_retry), .lcl_req(lcl_req), .lcl_we(lcl_we), .lcl_ack(lcl_ack),
  .lcl_rdata(lcl_rdata), .lm_req(lm_req), .lm_we(lm_we), .lm_addr(lm_addr),
  .lm_wdata(lm_wdata), .lm_ack(lm_ack), .local_error_interrupt_n(local_error_interrupt_n));

// file: tb/mem_model.sv
// Purpose: local memory answering the unit one word at a time
// Assumes: one access open at a time, answer after delay cycles
// Notes: read data toggles when not answering
`timescale 1ns/1ns
module mem_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic lm_req,
  input wire logic lm_we,
  input wire logic [31:0] lm_addr,
  input wire logic [31:0] lm_wdata,
  input wire logic [3:0] delay,
  output logic lm_ack,
  output logic [31:0] lm_rdata
);
  logic [31:0] mem [logic [31:0]]; // sparse word store
  logic [3:0] wait_q; // cycles waited on the open access
  initial begin
    lm_ack = 1'b0;
    lm_rdata = 32'h0000_0000;
    wait_q = 4'h0;
  end
  always @(posedge clk) begin
    lm_ack <= 1'b0;
    lm_rdata <= ~lm_rdata;
    if (srst || !lm_req || lm_ack) begin
      wait_q <= 4'h0;
    end else if (wait_q < delay) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      lm_ack <= 1'b1;
      if (lm_we) begin
        mem[lm_addr] = lm_wdata;
      end else begin
        lm_rdata <= mem.exists(lm_addr) ? mem[lm_addr] : ~lm_addr;
      end
    end
  end
endmodule

// file: tb/testbench.sv
// Purpose: self-checking bench of the message queue unit
// Assumes: base 0x123 in bits 31:20, 4K-entry queues of 0x4000 bytes
// Notes: the bench plays the pci master and the local processor
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic srst, pci_req, pci_we, pci_ack, pci_retry, lcl_req, lcl_we, lcl_ack;
  logic lm_req, lm_we, lm_ack, local_interrupt, local_error_interrupt_n, rt;
  logic [7:0] pci_addr, lcl_addr;
  logic [31:0] pci_wdata, pci_rdata, lcl_wdata, lcl_rdata, lm_addr, lm_wdata, lm_rdata, rd;
  logic [3:0] delay; // memory answer delay
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  int wt; // cycles the last pci answer took
  message_queue_unit i_message_queue_unit (.clk(clk), .srst(srst), .pci_req(pci_req),
    .pci_we(pci_we), .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_ack(pci_ack),
    .pci_retry(pci_retry), .pci_rdata(pci_rdata), .lcl_req(lcl_req), .lcl_we(lcl_we),
    .lcl_addr(lcl_addr), .lcl_wdata(lcl_wdata), .lcl_ack(lcl_ack), .lcl_rdata(lcl_rdata),
    .lm_req(lm_req), .lm_we(lm_we), .lm_addr(lm_addr), .lm_wdata(lm_wdata), .lm_ack(lm_ack),
    .lm_rdata(lm_rdata), .local_interrupt(local_interrupt),
    .local_error_interrupt_n(local_error_interrupt_n));
  mem_model i_mem_model (.clk(clk), .srst(srst), .lm_req(lm_req), .lm_we(lm_we),
    .lm_addr(lm_addr), .lm_wdata(lm_wdata), .delay(delay), .lm_ack(lm_ack), .lm_rdata(lm_rdata));
  always #10 clk = ~clk;
  // compare one value
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one local register access, answer one cycle later
  task automatic lcl(input logic we, input logic [7:0] addr, input logic [31:0] wd);
    @(negedge clk);
    lcl_req = 1'b1;
    lcl_we = we;
    lcl_addr = addr;
    lcl_wdata = wd;
    @(negedge clk);
    rd = lcl_rdata;
    check("lcl_ack", 32'h1, {31'h0, lcl_ack});
    lcl_req = 1'b0;
  endtask
  // one pci access; again repeats it while refused
  task automatic pci(input logic we, input logic [7:0] addr, input logic [31:0] wd,
                     input logic again);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      pci_req = 1'b1;
      pci_we = we;
      pci_addr = addr;
      pci_wdata = wd;
      @(negedge clk);
      pci_req = 1'b0;
      wt = 0;
      while (pci_ack !== 1'b1 && pci_retry !== 1'b1 && n < 60) begin
        n++;
        wt++;
        @(negedge clk);
      end
      rd = pci_rdata;
      rt = pci_retry;
    end while (rt === 1'b1 && again && n < 60);
    check("pci answered", 32'h1, {31'h0, n < 60});
  endtask
  // wait for the memory access and pointer update
  task automatic settle();
    int n;
    n = 0;
    while (lm_req !== 1'b0 && n < 40) begin
      n++;
      @(negedge clk);
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    {srst, pci_req, pci_we, lcl_req, lcl_we} = 5'b1_0000;
    {pci_addr, lcl_addr, pci_wdata, lcl_wdata} = 80'h0;
    delay = 4'h3;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    lcl(1'b0, 8'h00, 32'h0); check("config reset", 32'h0, rd);
    pci(1'b0, 8'h40, 32'h0, 1'b0); check("disabled read", 32'hFFFF_FFFF, rd);
    // processor fills lists and loads pointers, then enables
    lcl(1'b1, 8'h04, 32'h1230_0000);
    lcl(1'b1, 8'h18, 32'h0000_3FFC);
    lcl(1'b1, 8'h1C, 32'h0000_3FFC);
    lcl(1'b1, 8'h28, 32'h0000_3FFC);
    i_mem_model.mem[32'h1230_0000] = 32'h0000_2000;
    i_mem_model.mem[32'h1230_0004] = 32'h0000_3000;
    lcl(1'b1, 8'h10, 32'h0000_0008);
    i_mem_model.mem[32'h1230_8000] = 32'h0000_5000;
    lcl(1'b1, 8'h20, 32'h0000_0004);
    lcl(1'b1, 8'h00, 32'h0000_0003);
    // inbound post at the last entry, then an outbound read refused while busy
    pci(1'b1, 8'h40, 32'h0000_1000, 1'b0); check("post retry", 32'h0, {31'h0, rt});
    pci(1'b0, 8'h44, 32'h0, 1'b0); check("busy retry", 32'h1, {31'h0, rt});
    settle();
    check("post word", 32'h0000_1000, i_mem_model.mem[32'h1230_7FFC]);
    lcl(1'b0, 8'h18, 32'h0); check("post head wrap", 32'h0, rd);
    check("post irq", 32'h1, {31'h0, local_interrupt});
    lcl(1'b0, 8'h08, 32'h0); check("post status", 32'h20, rd & 32'h20);
    lcl(1'b1, 8'h08, 32'h0000_0010);
    repeat (2) @(negedge clk);
    check("masked irq", 32'h0, {31'h0, local_interrupt});
    lcl(1'b1, 8'h1C, 32'h0000_0000);
    lcl(1'b0, 8'h08, 32'h0); check("post drained", 32'h0, rd & 32'h20);
    // inbound free reads, plain then prefetched
    pci(1'b0, 8'h40, 32'h0, 1'b1); check("free read", 32'h0000_2000, rd);
    lcl(1'b0, 8'h14, 32'h0); check("free tail", 32'h4, rd);
    lcl(1'b1, 8'h08, 32'h0000_0018);
    settle();
    pci(1'b0, 8'h40, 32'h0, 1'b1); check("prefetched", 32'h0000_3000, rd);
    check("prefetch latency", 32'h0, wt);
    pci(1'b0, 8'h40, 32'h0, 1'b1); check("free empty", 32'hFFFF_FFFF, rd);
    lcl(1'b0, 8'h14, 32'h0); check("free tail end", 32'h8, rd);
    // outbound post, disabled then enabled
    lcl(1'b1, 8'h00, 32'h0000_0002);
    pci(1'b0, 8'h44, 32'h0, 1'b1); check("post disabled", 32'hFFFF_FFFF, rd);
    lcl(1'b1, 8'h00, 32'h0000_0003);
    pci(1'b0, 8'h44, 32'h0, 1'b1); check("out read", 32'h0000_5000, rd);
    pci(1'b0, 8'h44, 32'h0, 1'b1); check("out empty", 32'hFFFF_FFFF, rd);
    lcl(1'b0, 8'h24, 32'h0); check("out tail", 32'h4, rd);
    // outbound free write that overflows the list
    delay = 4'h0;
    pci(1'b1, 8'h44, 32'h0000_6000, 1'b1);
    settle();
    check("free word", 32'h0000_6000, i_mem_model.mem[32'h1230_FFFC]);
    lcl(1'b0, 8'h28, 32'h0); check("free head wrap", 32'h0, rd);
    check("overflow irq", 32'h0, {31'h0, local_error_interrupt_n});
    lcl(1'b0, 8'h08, 32'h0); check("overflow flag", 32'h40, rd & 32'h40);
    lcl(1'b1, 8'h08, 32'h0000_0058);
    repeat (2) @(negedge clk);
    check("overflow cleared", 32'h1, {31'h0, local_error_interrupt_n});
    // unmapped places read zero
    pci(1'b0, 8'h48, 32'h0, 1'b1); check("pci unmapped", 32'h0, rd);
    lcl(1'b0, 8'hF0, 32'h0); check("lcl unmapped", 32'h0, rd);
    tally_and_finish();
  end
endmodule
